/* File: hdl/ofs_offline_frame_search.sv */
// offline frame alignment search engine with wishbone register slave
`timescale 1ns/100ps
// Behaviour
// - one search engine per framer, shared by receive and transmit; one search at a time.
// - result bits may last one cycle; pending request relaunches search, clearing result.
// - no-candidate bit 4 set when search ends without candidates; low otherwise.
// - found sets bit 3, clears direction loss-of-frame, realigns timebase, goes idle.
// - receive realignment to a new position increments the alignment-change counter.
// - timeout bit 2 is cleared on entering the running state.
// - several candidates surviving the whole interval latch timeout and end search.
// - forced reframe runs a single search lasting at most 24 ms.
// - after timeout a still-asserted loss-of-frame request starts a fresh search.
// - timeout is 12 ms for T1 SF, 24 ms for T1 ESF, 8 ms for E1.
// - running bit 1 set on forced or loss-of-frame reframe request.
// - running lasts until found, abort, timeout, or all candidates eliminated.
// - forced request clears loss-of-frame only on success, like any run; forced bit self-clears on entry.
// - direction bit 0 updated on entry: 1 receive line, 0 transmit bus data.
// - E1 receive searches report frame, multiframe, signaling progress flags.
// - found only when exactly one candidate remains.
module ofs_offline_frame_search import ofs_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rx_loss_of_frame_i,
	input wire logic tx_loss_of_frame_i,
	input wire logic [7:0] candidate_count_i,
	input wire logic [7:0] candidate_pos_i,
	input wire logic basic_frame_seen_i,
	input wire logic multiframe_seen_i,
	input wire logic signaling_multiframe_seen_i,
	output logic search_rx_o,
	output logic search_tx_o,
	output logic search_bus_o,
	output logic rx_loss_of_frame_clear_o,
	output logic tx_loss_of_frame_clear_o,
	output logic rx_realign_o,
	output logic tx_realign_o,
	output logic tx_bus_timebase_realign_o,
	output logic [7:0] realign_pos_o,
	output logic irq_o
);
	ofs_state_t state;
	logic [7:0] offline_search_status;
	logic rx_forced_reframe;
	logic tx_forced_reframe;
	logic rx_search_abort;
	logic tx_search_abort;
	logic search_bus_sel;
	ofs_mode_t rx_mode;
	ofs_mode_t tx_mode;
	logic [OFS_IRQ_W-1:0] irq_stat;
	logic [OFS_IRQ_W-1:0] irq_mask;
	logic [15:0] alignment_change_counter;
	logic [7:0] rx_align_pos;
	logic basic_frame_progress;
	logic multiframe_progress;
	logic signaling_multiframe_progress;
	logic [OFS_TMR_W-1:0] timer;
	logic [OFS_TMR_W-1:0] limit;
	logic dir_rx;
	logic last_rx;
	logic forced_run;
	logic rx_req;
	logic tx_req;
	logic start;
	logic next_dir_rx;
	logic abort_now;
	logic end_found;
	logic end_invalid;
	logic end_timeout;
	logic [OFS_IRQ_W-1:0] irq_event;
	logic wr;
	logic rd_cycle;
	ofs_mode_t cur_mode;
	logic found_mask_rx;
	logic found_mask_tx;
	logic rx_lof_req;
	logic tx_lof_req;
	logic search_end;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic [2:0] progress_seen;
	logic [2:0] progress_flags;
	logic progress_track;

	// the online framer drops its request one cycle after the clear pulse;
	// masking that cycle keeps a success from relaunching a stale search
	assign rx_lof_req = rx_loss_of_frame_i && !found_mask_rx;
	assign tx_lof_req = tx_loss_of_frame_i && !found_mask_tx;
	assign rx_req = rx_lof_req | rx_forced_reframe;
	assign tx_req = tx_lof_req | tx_forced_reframe;
	assign search_end = abort_now || end_found || end_invalid || end_timeout;
	assign start = (state != OFS_RUN) && (rx_req || tx_req);
	// alternate on contention: the last served direction yields
	assign next_dir_rx = rx_req && (!tx_req || !last_rx);
	assign cur_mode = dir_rx ? rx_mode : tx_mode;
	assign abort_now = dir_rx ? rx_search_abort : tx_search_abort;
	assign end_found = (state == OFS_RUN) && !abort_now && candidate_count_i == 8'h01;
	assign end_invalid = (state == OFS_RUN) && !abort_now && candidate_count_i == 8'h00;
	assign end_timeout = (state == OFS_RUN) && !abort_now && candidate_count_i > 8'h01 && timer >= limit;
	// writes land on the edge at which the master samples ack high
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	assign wr_ctrl = wr && wb_adr_i == OFS_ADDR_CTRL;
	assign wr_mode = wr && wb_adr_i == OFS_ADDR_MODE;
	assign wr_irq_stat = wr && wb_adr_i == OFS_ADDR_IRQ_STAT;
	assign wr_irq_mask = wr && wb_adr_i == OFS_ADDR_IRQ_MASK;
	assign rd_cycle = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign irq_event = {end_found && dir_rx && candidate_pos_i != rx_align_pos, end_timeout, end_invalid, end_found};

	always_comb begin
		case (cur_mode)
			OFS_MODE_T1_SF: limit = OFS_TMR_W'(OFS_TMO_T1_SF_CYC);
			OFS_MODE_T1_ESF: limit = OFS_TMR_W'(OFS_TMO_T1_ESF_CYC);
			OFS_MODE_E1: limit = OFS_TMR_W'(OFS_TMO_E1_CYC);
			default: limit = OFS_TMR_W'(OFS_TMO_T1_ESF_CYC);
		endcase
		if (forced_run) begin
			limit = OFS_TMR_W'(OFS_TMO_FORCE_CYC);
		end
	end

	// single engine, so one state register serves both directions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= OFS_IDLE;
		end else begin
			case (state)
				OFS_IDLE: if (start) begin
					state <= OFS_RUN;
				end
				OFS_RUN: if (search_end) begin
					state <= OFS_DONE;
				end
				OFS_DONE: if (start) begin
					state <= OFS_RUN;
				end else begin
					state <= OFS_IDLE;
				end
				default: state <= OFS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_rx <= 1'b1;
			last_rx <= 1'b0;
			forced_run <= 1'b0;
			timer <= '0;
		end else if (start) begin
			dir_rx <= next_dir_rx;
			last_rx <= next_dir_rx;
			forced_run <= next_dir_rx ? rx_forced_reframe : tx_forced_reframe;
			timer <= '0;
		end else if (state == OFS_RUN && timer != limit) begin
			timer <= timer + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			offline_search_status <= 8'h01;
		end else if (start) begin
			offline_search_status <= '0;
			offline_search_status[OFS_ACTIVE_BIT] <= 1'b1;
			offline_search_status[OFS_DIR_BIT] <= next_dir_rx;
		end else if (state == OFS_RUN) begin
			if (search_end) begin
				offline_search_status[OFS_ACTIVE_BIT] <= 1'b0;
			end
			offline_search_status[OFS_FOUND_BIT] <= end_found;
			offline_search_status[OFS_INVALID_BIT] <= end_invalid;
			offline_search_status[OFS_TIMEOUT_BIT] <= end_timeout;
		end
	end

	// control register; forced bits self-clear on entry to running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_forced_reframe <= 1'b0;
			tx_forced_reframe <= 1'b0;
			rx_search_abort <= 1'b0;
			tx_search_abort <= 1'b0;
			search_bus_sel <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				rx_search_abort <= wb_dat_i[OFS_CTRL_RXA];
				tx_search_abort <= wb_dat_i[OFS_CTRL_TXA];
				search_bus_sel <= wb_dat_i[OFS_CTRL_BUS];
			end
			if (start && next_dir_rx) begin
				rx_forced_reframe <= 1'b0;
			end else if (wr_ctrl && wb_dat_i[OFS_CTRL_RXF]) begin
				rx_forced_reframe <= 1'b1;
			end
			if (start && !next_dir_rx) begin
				tx_forced_reframe <= 1'b0;
			end else if (wr_ctrl && wb_dat_i[OFS_CTRL_TXF]) begin
				tx_forced_reframe <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_mode <= OFS_MODE_T1_SF;
			tx_mode <= OFS_MODE_T1_SF;
		end else if (wr_mode) begin
			rx_mode <= ofs_mode_t'(wb_dat_i[1:0]);
			tx_mode <= ofs_mode_t'(wb_dat_i[5:4]);
		end
	end

	// realignment and loss-of-frame clear pulses; forced runs clear too only on success
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_loss_of_frame_clear_o <= 1'b0;
			tx_loss_of_frame_clear_o <= 1'b0;
			rx_realign_o <= 1'b0;
			tx_realign_o <= 1'b0;
			tx_bus_timebase_realign_o <= 1'b0;
			realign_pos_o <= '0;
			rx_align_pos <= '0;
			alignment_change_counter <= '0;
		end else begin
			rx_loss_of_frame_clear_o <= end_found && dir_rx;
			tx_loss_of_frame_clear_o <= end_found && !dir_rx;
			rx_realign_o <= end_found && dir_rx;
			tx_realign_o <= end_found && !dir_rx && !search_bus_sel;
			tx_bus_timebase_realign_o <= end_found && !dir_rx && search_bus_sel;
			if (end_found) begin
				realign_pos_o <= candidate_pos_i;
			end
			if (end_found && dir_rx) begin
				rx_align_pos <= candidate_pos_i;
				if (candidate_pos_i != rx_align_pos) begin
					alignment_change_counter <= alignment_change_counter + 1'b1;
				end
			end
		end
	end

	// one cycle of mask after each success, per direction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			found_mask_rx <= 1'b0;
			found_mask_tx <= 1'b0;
		end else begin
			found_mask_rx <= end_found && dir_rx;
			found_mask_tx <= end_found && !dir_rx;
		end
	end

	// progress flags track e1 receive searches only
	assign progress_seen = {signaling_multiframe_seen_i, multiframe_seen_i, basic_frame_seen_i};
	assign progress_track = state == OFS_RUN && dir_rx && rx_mode == OFS_MODE_E1;
	// flags stay after the search ends, so software can still see how far it got
	for (genvar g = 0; g < 3; g++) begin : g_progress
		always_ff @(posedge clk_i) begin
			if (rst_i || start) begin
				progress_flags[g] <= 1'b0;
			end else if (progress_track && progress_seen[g]) begin
				progress_flags[g] <= 1'b1;
			end
		end
	end
	assign basic_frame_progress = progress_flags[0];
	assign multiframe_progress = progress_flags[1];
	assign signaling_multiframe_progress = progress_flags[2];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			search_rx_o <= 1'b0;
			search_tx_o <= 1'b0;
			search_bus_o <= 1'b0;
		end else begin
			search_rx_o <= (start && next_dir_rx) || (state == OFS_RUN && dir_rx && !search_end);
			search_tx_o <= (start && !next_dir_rx) || (state == OFS_RUN && !dir_rx && !search_end);
			search_bus_o <= search_bus_sel;
		end
	end

	// sticky events: set beats a write-one clear in the same cycle
	for (genvar g = 0; g < OFS_IRQ_W; g++) begin : g_irq
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				irq_stat[g] <= 1'b0;
				irq_mask[g] <= 1'b0;
			end else begin
				if (irq_event[g]) begin
					irq_stat[g] <= 1'b1;
				end else if (wr_irq_stat && wb_dat_i[g]) begin
					irq_stat[g] <= 1'b0;
				end
				if (wr_irq_mask) begin
					irq_mask[g] <= wb_dat_i[g];
				end
			end
		end
	end

	// event folded in so the line rises with the status bit, not a cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |((irq_stat | irq_event) & irq_mask);
		end
	end

	// one-wait-state slave; reads have no side effect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= rd_cycle;
			wb_dat_o <= '0;
			if (rd_cycle) begin
				case (wb_adr_i)
					OFS_ADDR_STATUS: wb_dat_o <= {27'h0, offline_search_status[4:0]};
					OFS_ADDR_CTRL: wb_dat_o <= {27'h0, search_bus_sel, tx_search_abort, rx_search_abort,
						tx_forced_reframe, rx_forced_reframe};
					OFS_ADDR_MODE: wb_dat_o <= {26'h0, tx_mode, 2'h0, rx_mode};
					OFS_ADDR_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat};
					OFS_ADDR_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask};
					OFS_ADDR_COUNT: wb_dat_o <= {16'h0, alignment_change_counter};
					OFS_ADDR_PROGRESS: wb_dat_o <= {29'h0, signaling_multiframe_progress, multiframe_progress,
						basic_frame_progress};
					default: wb_dat_o <= '0;
				endcase
			end
		end
	end
endmodule

/* File: hdl/ofs_pkg.sv */
// package: register map, field layout, timing and enumerations for the offline frame search engine
package ofs_pkg;
	localparam logic [7:0] OFS_STATUS_IDX = 8'h17;
	localparam logic [9:0] OFS_ADDR_STATUS = 10'h05c;
	localparam logic [9:0] OFS_ADDR_CTRL = 10'h000;
	localparam logic [9:0] OFS_ADDR_MODE = 10'h004;
	localparam logic [9:0] OFS_ADDR_IRQ_STAT = 10'h008;
	localparam logic [9:0] OFS_ADDR_IRQ_MASK = 10'h00c;
	localparam logic [9:0] OFS_ADDR_COUNT = 10'h010;
	localparam logic [9:0] OFS_ADDR_PROGRESS = 10'h014;
	localparam int OFS_DIR_BIT = 0;
	localparam int OFS_ACTIVE_BIT = 1;
	localparam int OFS_TIMEOUT_BIT = 2;
	localparam int OFS_FOUND_BIT = 3;
	localparam int OFS_INVALID_BIT = 4;
	localparam int OFS_CTRL_RXF = 0;
	localparam int OFS_CTRL_TXF = 1;
	localparam int OFS_CTRL_RXA = 2;
	localparam int OFS_CTRL_TXA = 3;
	localparam int OFS_CTRL_BUS = 4;
	localparam int OFS_IRQ_FOUND = 0;
	localparam int OFS_IRQ_INVALID = 1;
	localparam int OFS_IRQ_TIMEOUT = 2;
	localparam int OFS_IRQ_ALIGNMENT_CHANGE_COUNTER = 3;
	localparam int OFS_IRQ_W = 4;
	localparam int OFS_CLK_KHZ = 40000;
	localparam int OFS_TMO_T1_SF_MS = 12;
	localparam int OFS_TMO_T1_ESF_MS = 24;
	localparam int OFS_TMO_E1_MS = 8;
	localparam int OFS_TMO_FORCE_MS = 24;
	localparam int OFS_TMO_T1_SF_CYC = OFS_TMO_T1_SF_MS * OFS_CLK_KHZ;
	localparam int OFS_TMO_T1_ESF_CYC = OFS_TMO_T1_ESF_MS * OFS_CLK_KHZ;
	localparam int OFS_TMO_E1_CYC = OFS_TMO_E1_MS * OFS_CLK_KHZ;
	localparam int OFS_TMO_FORCE_CYC = OFS_TMO_FORCE_MS * OFS_CLK_KHZ;
	localparam int OFS_TMR_W = 20;
	typedef enum logic [1:0] {
		OFS_MODE_T1_SF = 2'h0,
		OFS_MODE_T1_ESF = 2'h1,
		OFS_MODE_E1 = 2'h2
	} ofs_mode_t;
	typedef enum logic [2:0] {
		OFS_IDLE = 3'b001,
		OFS_RUN = 3'b010,
		OFS_DONE = 3'b100
	} ofs_state_t;
endpackage

/* File: verif/ofs_offline_frame_search_properties.sv */
// checker: port-level properties of the search engine
`timescale 1ns/100ps
module ofs_search_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_ack_o,
	input wire logic [7:0] candidate_count_i,
	input wire logic search_rx_o,
	input wire logic search_tx_o,
	input wire logic rx_loss_of_frame_clear_o,
	input wire logic tx_loss_of_frame_clear_o,
	input wire logic rx_realign_o,
	input wire logic tx_realign_o,
	input wire logic tx_bus_timebase_realign_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_rx_one;
		search_rx_o && candidate_count_i == 8'h01;
	endsequence
	sequence s_tx_none;
		search_tx_o && candidate_count_i == 8'h00;
	endsequence
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	chk_one_search: assert property (!(search_rx_o && search_tx_o))
		else $error("two searches at once");
	chk_one_realign: assert property (!(rx_realign_o && (tx_realign_o || tx_bus_timebase_realign_o)))
		else $error("two realigns at once");
	chk_rx_clear_pair: assert property (rx_loss_of_frame_clear_o |-> rx_realign_o)
		else $error("rx clear without realign");
	chk_tx_clear_pair: assert property (tx_loss_of_frame_clear_o |-> tx_realign_o || tx_bus_timebase_realign_o)
		else $error("tx clear without realign");
	chk_realign_pulse: assert property (rx_realign_o |=> !rx_realign_o)
		else $error("realign pulse too long");
	chk_found_single: assert property (rx_realign_o |-> $past(candidate_count_i, 1) == 8'h01)
		else $error("found without single candidate");
	chk_found_ends: assert property (s_rx_one |-> ##[1:3] !search_rx_o)
		else $error("search not ended on find");
	chk_none_ends: assert property (s_tx_none |-> ##[1:3] !search_tx_o)
		else $error("search not ended on no candidate");
endmodule
bind ofs_offline_frame_search ofs_search_checker i_ofs_search_checker (.clk_i, .rst_i, .wb_ack_o,
	.candidate_count_i, .search_rx_o, .search_tx_o, .rx_loss_of_frame_clear_o, .tx_loss_of_frame_clear_o,
	.rx_realign_o, .tx_realign_o, .tx_bus_timebase_realign_o);

/* File: verif/ofs_framer_model.sv */
// model: online framers holding loss-of-frame requests
`timescale 1ns/100ps
module ofs_framer_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rx_raise_i,
	input wire logic tx_raise_i,
	input wire logic rx_clear_i,
	input wire logic tx_clear_i,
	output logic rx_loss_of_frame_o,
	output logic tx_loss_of_frame_o
);
	// level held until success, so the engine may relaunch meanwhile
	always_ff @(posedge clk_i) begin
		if (rst_i) rx_loss_of_frame_o <= 1'b0;
		else if (rx_clear_i) rx_loss_of_frame_o <= 1'b0;
		else if (rx_raise_i) rx_loss_of_frame_o <= 1'b1;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) tx_loss_of_frame_o <= 1'b0;
		else if (tx_clear_i) tx_loss_of_frame_o <= 1'b0;
		else if (tx_raise_i) tx_loss_of_frame_o <= 1'b1;
	end
endmodule

/* File: verif/ofs_offline_frame_search_tb.sv */
// bench: directed scenarios for the search engine
`timescale 1ns/100ps
module ofs_offline_frame_search_tb;
	import ofs_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [9:0] adr = 10'h000;
	logic [31:0] dat = 32'h0, wb_dat_o, rd;
	logic [7:0] cnt = 8'h00, pos = 8'h00, realign_pos_o;
	logic we = 1'b0, cyc = 1'b0, wb_ack_o, irq_o, rx_raise = 1'b0, tx_raise = 1'b0;
	logic rx_lof, tx_lof, rx_clr, tx_clr, rx_rea, tx_rea, tx_bus, sbus;
	logic [2:0] seen = 3'h0;
	int n_mismatch = 0, comparisons = 0;
	ofs_offline_frame_search i_ofs_offline_frame_search (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .rx_loss_of_frame_i(rx_lof), .tx_loss_of_frame_i(tx_lof),
		.candidate_count_i(cnt), .candidate_pos_i(pos), .basic_frame_seen_i(seen[0]),
		.multiframe_seen_i(seen[1]), .signaling_multiframe_seen_i(seen[2]), .search_rx_o(), .search_tx_o(),
		.search_bus_o(sbus),
		.rx_loss_of_frame_clear_o(rx_clr), .tx_loss_of_frame_clear_o(tx_clr), .rx_realign_o(rx_rea),
		.tx_realign_o(tx_rea), .tx_bus_timebase_realign_o(tx_bus), .realign_pos_o(realign_pos_o), .irq_o(irq_o));
	ofs_framer_model i_ofs_framer_model (.clk_i(clk_i), .rst_i(rst_i), .rx_raise_i(rx_raise),
		.tx_raise_i(tx_raise), .rx_clear_i(rx_clr), .tx_clear_i(tx_clr), .rx_loss_of_frame_o(rx_lof),
		.tx_loss_of_frame_o(tx_lof));
	initial forever #12.5 clk_i = ~clk_i;
	task end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// classic cycle: request held until the edge that samples ack
	task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 20) begin
				n_mismatch++;
				end_sim();
			end
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task rchk(input logic [9:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task wait_rea(input logic tx);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 40) begin
				n_mismatch++;
				end_sim();
			end
		end while ((tx ? tx_rea : rx_rea) !== 1'b1);
	endtask
	task t_reset;
		rchk(OFS_ADDR_STATUS, 32'h01);
		rchk(OFS_ADDR_STATUS, 32'h01);
		rchk(10'h3fc, 32'h0);
		$display("reset done");
	endtask
	task t_rx_found;
		cnt <= 8'h01;
		pos <= 8'h2a;
		wb(1'b1, OFS_ADDR_MODE, 32'h02);
		wb(1'b1, OFS_ADDR_IRQ_MASK, 32'h0f);
		wb(1'b1, OFS_ADDR_CTRL, 32'h01);
		wait_rea(1'b0);
		rchk(OFS_ADDR_STATUS, 32'h09);
		chk({24'h0, realign_pos_o}, 32'h2a);
		rchk(OFS_ADDR_CTRL, 32'h0);
		rchk(OFS_ADDR_COUNT, 32'h01);
		chk({31'h0, irq_o}, 32'h1);
		rchk(OFS_ADDR_IRQ_STAT, 32'h09);
		wb(1'b1, OFS_ADDR_IRQ_STAT, 32'h0f);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		wb(1'b1, OFS_ADDR_IRQ_MASK, 32'h0);
		wb(1'b1, OFS_ADDR_CTRL, 32'h01);
		wait_rea(1'b0);
		rchk(OFS_ADDR_COUNT, 32'h01);
		rchk(OFS_ADDR_IRQ_STAT, 32'h01);
		chk({31'h0, irq_o}, 32'h0);
		$display("rx found done");
	endtask
	// no candidate first: the held request keeps relaunching
	task t_tx_lof;
		cnt <= 8'h00;
		tx_raise <= 1'b1;
		@(posedge clk_i);
		tx_raise <= 1'b0;
		repeat (8) @(posedge clk_i);
		cnt <= 8'h01;
		pos <= 8'h33;
		wait_rea(1'b1);
		repeat (8) @(posedge clk_i);
		chk({31'h0, tx_lof}, 32'h0);
		rchk(OFS_ADDR_STATUS, 32'h08);
		rchk(OFS_ADDR_COUNT, 32'h01);
		$display("tx lof done");
	endtask
	task t_tx_none;
		cnt <= 8'h00;
		wb(1'b1, OFS_ADDR_CTRL, 32'h02);
		repeat (4) @(posedge clk_i);
		rchk(OFS_ADDR_STATUS, 32'h10);
		rchk(OFS_ADDR_CTRL, 32'h0);
		$display("tx none done");
	endtask
	task t_abort;
		cnt <= 8'h02;
		wb(1'b1, OFS_ADDR_CTRL, 32'h05);
		repeat (4) @(posedge clk_i);
		rchk(OFS_ADDR_STATUS, 32'h01);
		wb(1'b1, OFS_ADDR_CTRL, 32'h0);
		rchk(OFS_ADDR_COUNT, 32'h01);
		$display("abort done");
	endtask
	task t_progress;
		cnt <= 8'h02;
		seen <= 3'h5;
		wb(1'b1, OFS_ADDR_CTRL, 32'h01);
		repeat (4) @(posedge clk_i);
		rchk(OFS_ADDR_STATUS, 32'h03);
		rchk(OFS_ADDR_PROGRESS, 32'h05);
		wb(1'b1, OFS_ADDR_CTRL, 32'h04);
		seen <= 3'h0;
		repeat (3) @(posedge clk_i);
		rchk(OFS_ADDR_STATUS, 32'h01);
		wb(1'b1, OFS_ADDR_CTRL, 32'h0);
		$display("progress done");
	endtask
	task t_bus;
		int n;
		n = 0;
		cnt <= 8'h01;
		pos <= 8'h44;
		wb(1'b1, OFS_ADDR_CTRL, 32'h12);
		do begin
			@(posedge clk_i);
			n++;
			if (n > 40) begin
				n_mismatch++;
				end_sim();
			end
		end while (tx_bus !== 1'b1);
		chk({30'h0, sbus, tx_rea}, 32'h2);
		chk({24'h0, realign_pos_o}, 32'h44);
		rchk(OFS_ADDR_STATUS, 32'h08);
		rchk(OFS_ADDR_COUNT, 32'h01);
		wb(1'b1, OFS_ADDR_CTRL, 32'h0);
		$display("bus done");
	endtask
	task t_rst;
		cnt <= 8'h02;
		wb(1'b1, OFS_ADDR_CTRL, 32'h01);
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(OFS_ADDR_STATUS, 32'h01);
		rchk(OFS_ADDR_CTRL, 32'h0);
		rchk(OFS_ADDR_COUNT, 32'h0);
		$display("mid reset done");
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_rx_found();
		t_tx_lof();
		t_tx_none();
		t_abort();
		t_progress();
		t_bus();
		t_rst();
		end_sim();
	end
endmodule
